// *** logic/rft_field_tx.sv ***
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module rft_field_tx #(
  parameter int IDT_CYCLES = rft_pkg::IDT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [rft_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // RF front-end pins
  input wire logic quartz_clk,
  input wire logic ext_field_det,
  // Transmit path from the framer
  input wire logic tx_envelope,
  // Amplitude measurement
  input wire logic meas_valid,
  input wire logic [6:0] meas_residual,
  // Card-side receiver
  input wire rft_pkg::rft_rx_evt_t rx_evt,
  input wire logic peer_type_a_seen,
  input wire logic peer_fsig_seen,
  // Antenna drivers
  output rft_pkg::rft_drv_pins_t antenna_drive_a,
  output rft_pkg::rft_drv_pins_t antenna_drive_b,
  // Residual carrier control
  output logic [4:0] mod_depth_trim,
  // Card answers
  output logic tx_answer_valid,
  output rft_pkg::rft_answer_t tx_answer_kind,
  output logic [1:0] card_rate,
  // Events
  output logic field_collision_error_irq,
  output logic card_activated_irq
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] pins_sync;
  logic quartz_s;
  logic ext_field_s;

  rft_sync #(
    .W(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({quartz_clk, ext_field_det}),
    .sync_out(pins_sync)
  );

  assign quartz_s = pins_sync[1];
  assign ext_field_s = pins_sync[0];

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  logic wr_cmd;
  logic wr_tx;
  logic wr_clk;
  logic wr_card;
  logic wr_card_st;
  logic field_enable_instr;
  logic field_disable_instr;
  logic act_clr;

  assign wr_cmd = reg_wr && (reg_addr == rft_pkg::ADDR_COMMAND);
  assign wr_tx = reg_wr && (reg_addr == rft_pkg::ADDR_TX_CTRL);
  assign wr_clk = reg_wr && (reg_addr == rft_pkg::ADDR_CLK_CTRL);
  assign wr_card = reg_wr && (reg_addr == rft_pkg::ADDR_CARD_CTRL);
  assign wr_card_st = reg_wr && (reg_addr == rft_pkg::ADDR_CARD_STATUS);
  assign field_enable_instr = wr_cmd && reg_wdata[rft_pkg::CMD_FIELD_ON_BIT];
  assign field_disable_instr = wr_cmd && reg_wdata[rft_pkg::CMD_FIELD_OFF_BIT];
  assign act_clr = wr_card_st && reg_wdata[rft_pkg::CARD_ACT_CLR_BIT];

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [4:0] resid_q;
  rft_pkg::rft_clk_cfg_t driver_clock_ctrl_reg_q;
  rft_pkg::rft_card_cfg_t card_cfg_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      resid_q <= rft_pkg::RESID_RESET;
      driver_clock_ctrl_reg_q <= rft_pkg::CLK_CFG_RESET;
      card_cfg_q <= rft_pkg::CARD_CFG_RESET;
    end else begin
      if (wr_tx) begin
        resid_q <= reg_wdata[4:0];
      end
      if (wr_clk) begin
        driver_clock_ctrl_reg_q <= reg_wdata[$bits(rft_pkg::rft_clk_cfg_t)-1:0];
      end
      if (wr_card) begin
        card_cfg_q <= reg_wdata[$bits(rft_pkg::rft_card_cfg_t)-1:0];
      end
    end
  end

  assign card_rate = card_cfg_q.rate;

  // ----------------------------------------------------------------------
  // Field switch-on with collision avoidance
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FLD_OFF, FLD_LISTEN, FLD_ON
  } rft_fld_state_t;

  rft_fld_state_t fld_q;
  rft_fld_state_t fld_d;
  logic [rft_pkg::IDT_CNT_W-1:0] idt_cnt_q;
  logic [rft_pkg::IDT_CNT_W-1:0] idt_cnt_d;
  logic idt_done;
  logic coll_err_q;
  logic coll_set;
  logic [1:0] cause_q;
  logic carrier_on;

  assign idt_done = (idt_cnt_q == rft_pkg::IDT_CNT_W'(IDT_CYCLES - 1));
  assign coll_set = (fld_q == FLD_LISTEN) && ext_field_s;
  assign carrier_on = (fld_q == FLD_ON);

  always_comb begin
    fld_d = fld_q;
    idt_cnt_d = idt_cnt_q;
    case (fld_q)
      FLD_OFF: begin
        if (field_enable_instr) begin
          fld_d = FLD_LISTEN;
          idt_cnt_d = '0;
        end
      end
      FLD_LISTEN: begin
        idt_cnt_d = idt_cnt_q + 1'b1;
        if (field_disable_instr || ext_field_s) begin
          fld_d = FLD_OFF;
        end else if (idt_done) begin
          fld_d = FLD_ON;
        end
      end
      FLD_ON: begin
        if (field_disable_instr) begin
          fld_d = FLD_OFF;
        end
      end
      default: fld_d = FLD_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fld_q <= FLD_OFF;
      idt_cnt_q <= '0;
    end else begin
      fld_q <= fld_d;
      idt_cnt_q <= idt_cnt_d;
    end
  end

  // The error and its cause stand until the next field-on attempt.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      coll_err_q <= 1'b0;
      cause_q <= rft_pkg::CAUSE_NONE;
    end else if (coll_set) begin
      coll_err_q <= 1'b1;
      cause_q <= rft_pkg::CAUSE_EXT_FIELD;
    end else if (field_enable_instr && fld_q == FLD_OFF) begin
      coll_err_q <= 1'b0;
      cause_q <= rft_pkg::CAUSE_NONE;
    end
  end

  assign field_collision_error_irq = coll_err_q;

  // ----------------------------------------------------------------------
  // Carrier clock: quartz halved
  // ----------------------------------------------------------------------
  logic quartz_prev_q;
  logic carrier_clk_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      quartz_prev_q <= 1'b0;
      carrier_clk_q <= 1'b0;
    end else begin
      quartz_prev_q <= quartz_s;
      if (quartz_s && !quartz_prev_q) begin
        carrier_clk_q <= !carrier_clk_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Driver stages
  // ----------------------------------------------------------------------
  logic inv_a;
  logic inv_b;
  logic pol_a;
  logic pol_b;
  logic env_mod;

  // Card emulation uses its own inversion pair, except in the high-side and low-side modes, which keep the reader pair.
  assign inv_a = card_cfg_q.card_role ? driver_clock_ctrl_reg_q.drv_a_invert_card
                                      : driver_clock_ctrl_reg_q.drv_a_invert_reader;
  assign inv_b = card_cfg_q.card_role ? driver_clock_ctrl_reg_q.drv_b_invert_card
                                      : driver_clock_ctrl_reg_q.drv_b_invert_reader;
  assign pol_a = driver_clock_ctrl_reg_q.glob_inv ^ inv_a;
  assign pol_b = driver_clock_ctrl_reg_q.glob_inv ^ inv_b;
  assign env_mod = tx_envelope;

  // Both stages share one mode field; there is no per-driver mode.
  rft_drv_stage u_drv_a (
    .clk_sys(clk_sys),
    .reset(reset),
    .carrier_en(carrier_on),
    .env_mod(env_mod),
    .mode(driver_clock_ctrl_reg_q.driver_mode_during_mod),
    .carrier_clk(carrier_clk_q),
    .pol_pp(pol_a),
    .pol_hs(driver_clock_ctrl_reg_q.drv_b_invert_reader),
    .pol_ls(driver_clock_ctrl_reg_q.drv_a_invert_reader),
    .pins(antenna_drive_a)
  );

  rft_drv_stage u_drv_b (
    .clk_sys(clk_sys),
    .reset(reset),
    .carrier_en(carrier_on),
    .env_mod(env_mod),
    .mode(driver_clock_ctrl_reg_q.driver_mode_during_mod),
    .carrier_clk(carrier_clk_q),
    .pol_pp(pol_b),
    .pol_hs(driver_clock_ctrl_reg_q.drv_b_invert_reader),
    .pol_ls(driver_clock_ctrl_reg_q.drv_a_invert_reader),
    .pins(antenna_drive_b)
  );

  // ----------------------------------------------------------------------
  // Residual carrier loop
  // ----------------------------------------------------------------------
  logic [6:0] resid_target;
  logic loop_active;
  logic too_high;
  logic too_low;
  logic [4:0] trim_q;

  assign resid_target = rft_pkg::RESID_PCT[resid_q*7 +: 7];
  // Only meaningful while the partial-depth mode is selected.
  assign loop_active = carrier_on && meas_valid
                    && (driver_clock_ctrl_reg_q.driver_mode_during_mod
                        == rft_pkg::MODE_PUSH_PULL);
  assign too_high = meas_residual > resid_target;
  assign too_low = meas_residual < resid_target;

  // One step per measurement keeps the loop slow but stable.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trim_q <= rft_pkg::RESID_RESET;
    end else if (loop_active) begin
      if (too_high && trim_q != 5'h1F) begin
        trim_q <= trim_q + 5'h01;
      end else if (too_low && trim_q != 5'h00) begin
        trim_q <= trim_q - 5'h01;
      end
    end
  end

  assign mod_depth_trim = trim_q;

  // ----------------------------------------------------------------------
  // Card-role activation
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CARD_IDLE, CARD_READY, CARD_ACTIVE, CARD_HALT
  } rft_card_state_t;

  rft_card_state_t card_q;
  rft_card_state_t card_d;
  logic ans_d;
  rft_pkg::rft_answer_t ans_kind_d;
  logic ans_q;
  rft_pkg::rft_answer_t ans_kind_q;
  logic act_set;
  logic activated_q;
  logic card_live;

  assign card_live = card_cfg_q.card_role && ext_field_s;

  always_comb begin
    card_d = card_q;
    ans_d = 1'b0;
    ans_kind_d = rft_pkg::ANS_ATQA;
    act_set = 1'b0;
    if (!card_live) begin
      card_d = CARD_IDLE;
    end else if (rx_evt.valid) begin
      case (card_q)
        CARD_IDLE, CARD_HALT: begin
          if (rx_evt.cmd == rft_pkg::CMD_WAKE) begin
            card_d = CARD_READY;
            ans_d = 1'b1;
            ans_kind_d = rft_pkg::ANS_ATQA;
          end
        end
        CARD_READY: begin
          if (rx_evt.cmd == rft_pkg::CMD_ANTICOLL) begin
            ans_d = 1'b1;
            ans_kind_d = rft_pkg::ANS_UID;
          end else if (rx_evt.cmd == rft_pkg::CMD_SELECT && rx_evt.uid_match) begin
            card_d = CARD_ACTIVE;
            ans_d = 1'b1;
            ans_kind_d = rft_pkg::ANS_SAK;
            act_set = 1'b1;
          end else begin
            card_d = CARD_IDLE;
          end
        end
        // Beyond activation the host owns the protocol.
        CARD_ACTIVE: begin
          if (rx_evt.cmd == rft_pkg::CMD_HALT) begin
            card_d = CARD_HALT;
          end
        end
        default: card_d = CARD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      card_q <= CARD_IDLE;
      ans_q <= 1'b0;
      ans_kind_q <= rft_pkg::ANS_ATQA;
    end else begin
      card_q <= card_d;
      ans_q <= ans_d;
      ans_kind_q <= ans_kind_d;
    end
  end

  // Set wins over a software clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      activated_q <= 1'b0;
    end else if (act_set) begin
      activated_q <= 1'b1;
    end else if (act_clr) begin
      activated_q <= 1'b0;
    end
  end

  assign tx_answer_valid = ans_q;
  assign tx_answer_kind = ans_kind_q;
  assign card_activated_irq = activated_q && card_cfg_q.act_irq_en;

  // ----------------------------------------------------------------------
  // Mode detector
  // ----------------------------------------------------------------------
  logic [1:0] peer_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      peer_q <= rft_pkg::PEER_NONE;
    end else if (!card_live) begin
      peer_q <= rft_pkg::PEER_NONE;
    end else if (peer_type_a_seen) begin
      peer_q <= rft_pkg::PEER_TYPE_A;
    end else if (peer_fsig_seen) begin
      peer_q <= rft_pkg::PEER_FSIG;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [31:0] rd_field_status;
  logic [31:0] rd_card_status;
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;

  assign rd_field_status = {26'h0, cause_q, ext_field_s, coll_err_q,
                            (fld_q == FLD_LISTEN), carrier_on};
  assign rd_card_status = {23'h0, trim_q, ext_field_s, peer_q, activated_q};
  assign rd_mux =
      (reg_addr == rft_pkg::ADDR_TX_CTRL) ? {27'h0, resid_q} :
      (reg_addr == rft_pkg::ADDR_CLK_CTRL) ? {24'h0, driver_clock_ctrl_reg_q} :
      (reg_addr == rft_pkg::ADDR_FIELD_STATUS) ? rd_field_status :
      (reg_addr == rft_pkg::ADDR_CARD_CTRL) ? {28'h0, card_cfg_q} :
      (reg_addr == rft_pkg::ADDR_CARD_STATUS) ? rd_card_status :
      32'h0;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// *** logic/rft_pkg.sv ***
`default_nettype none
package rft_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  // Collision-avoidance listen window in microseconds.
  localparam int IDT_US = 100;
  localparam int IDT_CYCLES = IDT_US * CLK_MHZ;
  localparam int IDT_CNT_W = 24;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TX_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CLK_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_FIELD_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CARD_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CARD_STATUS = 8'h14;

  localparam int CMD_FIELD_ON_BIT = 0;
  localparam int CMD_FIELD_OFF_BIT = 1;
  localparam int CARD_ACT_CLR_BIT = 0;

  // ----------------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_HIZ = 3'h0,
    MODE_LOW = 3'h1,
    MODE_HIGH = 3'h2,
    MODE_LS_PULL = 3'h5,
    MODE_HS_PUSH = 3'h6,
    MODE_PUSH_PULL = 3'h7
  } rft_mode_t;

  typedef struct packed {
    logic glob_inv;
    logic drv_b_invert_card;
    logic drv_a_invert_card;
    logic drv_b_invert_reader;
    logic drv_a_invert_reader;
    logic [2:0] driver_mode_during_mod;
  } rft_clk_cfg_t;

  typedef struct packed {
    logic [1:0] rate;
    logic act_irq_en;
    logic card_role;
  } rft_card_cfg_t;

  // Gate controls of one driver; both low leaves the pin floating.
  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } rft_drv_pins_t;

  // Decoded layer-3 command from the card-side receiver.
  typedef enum logic [1:0] {
    CMD_WAKE, CMD_ANTICOLL, CMD_SELECT, CMD_HALT
  } rft_card_cmd_t;

  typedef struct packed {
    logic valid;
    rft_card_cmd_t cmd;
    logic uid_match;
  } rft_rx_evt_t;

  typedef enum logic [1:0] {
    ANS_ATQA, ANS_UID, ANS_SAK
  } rft_answer_t;

  localparam logic [1:0] PEER_NONE = 2'h0;
  localparam logic [1:0] PEER_TYPE_A = 2'h1;
  localparam logic [1:0] PEER_FSIG = 2'h2;

  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_EXT_FIELD = 2'h1;

  localparam logic [4:0] RESID_RESET = 5'h00;
  localparam rft_clk_cfg_t CLK_CFG_RESET = '0;
  localparam rft_card_cfg_t CARD_CFG_RESET = '0;

  // Nominal residual carrier in percent, index = residual code.
  localparam logic [7*32-1:0] RESID_PCT = {
    7'd0, 7'd25, 7'd30, 7'd35, 7'd40, 7'd45, 7'd55, 7'd60,
    7'd65, 7'd68, 7'd70, 7'd72, 7'd74, 7'd75, 7'd76, 7'd77,
    7'd78, 7'd79, 7'd80, 7'd81, 7'd82, 7'd83, 7'd84, 7'd85,
    7'd86, 7'd87, 7'd89, 7'd91, 7'd94, 7'd96, 7'd98, 7'd100
  };

endpackage
`default_nettype wire

// *** logic/rft_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module rft_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

// *** logic/rft_drv_stage.sv ***
`timescale 1ns/1ns
`default_nettype none
module rft_drv_stage (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic carrier_en,
  input wire logic env_mod,
  input wire logic [2:0] mode,
  input wire logic carrier_clk,
  input wire logic pol_pp,
  input wire logic pol_hs,
  input wire logic pol_ls,
  // Driver gates
  output rft_pkg::rft_drv_pins_t pins
);

  logic c_pp;
  logic c_hs;
  logic c_ls;
  rft_pkg::rft_drv_pins_t pins_d;
  rft_pkg::rft_drv_pins_t pins_q;

  assign c_pp = carrier_clk ^ pol_pp;
  assign c_hs = carrier_clk ^ pol_hs;
  assign c_ls = carrier_clk ^ pol_ls;

  always_comb begin
    pins_d = '0;
    if (!carrier_en) begin
      pins_d = '0;
    end else if (!env_mod) begin
      pins_d = '{hs_on: c_pp, ls_on: !c_pp};
    end else begin
      case (mode)
        rft_pkg::MODE_HIZ: pins_d = '0;
        rft_pkg::MODE_LOW: pins_d = '{hs_on: 1'b0, ls_on: 1'b1};
        rft_pkg::MODE_HIGH: pins_d = '{hs_on: 1'b1, ls_on: 1'b0};
        rft_pkg::MODE_HS_PUSH: pins_d = '{hs_on: c_hs, ls_on: 1'b0};
        rft_pkg::MODE_LS_PULL: pins_d = '{hs_on: 1'b0, ls_on: c_ls};
        // The envelope no longer gates the clock here.
        rft_pkg::MODE_PUSH_PULL: pins_d = '{hs_on: c_pp, ls_on: !c_pp};
        default: pins_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_d;
    end
  end

  assign pins = pins_q;

endmodule
`default_nettype wire

// *** test/rft_field_tx_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module rft_field_tx_asserts #(
  parameter int IDT_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port
  input wire logic [rft_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Modulation and drivers
  input wire logic tx_envelope,
  input wire rft_pkg::rft_drv_pins_t antenna_drive_a,
  input wire rft_pkg::rft_drv_pins_t antenna_drive_b,
  input wire logic field_collision_error_irq
);
  // ----
  // Mirrors of software state
  // ----
  wire logic cmd_wr = reg_wr && reg_addr == rft_pkg::ADDR_COMMAND;
  wire logic mode_wr = reg_wr && reg_addr == rft_pkg::ADDR_CLK_CTRL;
  wire logic both_off = antenna_drive_a == 2'h0 && antenna_drive_b == 2'h0;
  logic armed_q;
  logic [2:0] mode_q;
  // The mode copy lets the checks follow software without seeing the registers.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      armed_q <= 1'b0;
      mode_q <= 3'h0;
    end else begin
      armed_q <= armed_q | (cmd_wr & reg_wdata[0]);
      if (mode_wr) begin
        mode_q <= reg_wdata[2:0];
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_off;
    both_off;
  endsequence
  sequence s_on_wr;
    cmd_wr && reg_wdata[0] && both_off && !tx_envelope;
  endsequence
  sequence s_mod(m);
    tx_envelope && mode_q == m && antenna_drive_a != 2'h0;
  endsequence
  AST_IDLE_AT_START: assert property (!armed_q |-> s_off)
    else $error("carrier driven before field-on");
  AST_LISTEN_FIRST: assert property (s_on_wr |=> s_off [*8])
    else $error("carrier on during listen window");
  AST_COLLISION_OFF: assert property ($rose(field_collision_error_irq) |-> s_off [*4])
    else $error("carrier on after collision");
  AST_FIELD_OFF: assert property (cmd_wr && reg_wdata[1] |-> ##2 s_off)
    else $error("carrier still on after field-off");
  AST_MODE_LOW: assert property (s_mod(3'h1) |=> antenna_drive_a == 2'h1 && antenna_drive_b == 2'h1)
    else $error("mode low not applied");
  AST_HS_PUSH: assert property (s_mod(3'h6) |=> !antenna_drive_a.ls_on && !antenna_drive_b.ls_on)
    else $error("low side on in high-side mode");
  AST_LS_PULL: assert property (s_mod(3'h5) |=> !antenna_drive_a.hs_on && !antenna_drive_b.hs_on)
    else $error("high side on in low-side mode");
  AST_PUSH_PULL: assert property (s_mod(3'h7) |=> antenna_drive_a.hs_on != antenna_drive_a.ls_on
      && antenna_drive_b.hs_on != antenna_drive_b.ls_on)
    else $error("push-pull broken");
endmodule
bind rft_field_tx rft_field_tx_asserts #(.IDT_CYCLES(IDT_CYCLES)) u_chk (.clk_sys(clk_sys),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .tx_envelope(tx_envelope), .antenna_drive_a(antenna_drive_a),
  .antenna_drive_b(antenna_drive_b), .field_collision_error_irq(field_collision_error_irq));
`default_nettype wire

// *** test/rft_rf_peer.sv ***
`timescale 1ns/1ns
`default_nettype none
module rft_rf_peer (
  // Clock and field request
  input wire logic clk_sys,
  input wire logic field_req,
  // Toward the front end
  output logic quartz_clk,
  output logic ext_field_det,
  output rft_pkg::rft_rx_evt_t rx_evt,
  output logic peer_type_a_seen,
  output logic peer_fsig_seen
);
  // ----
  // Remote initiator
  // ----
  // Whole-ns steps only, so the quartz runs slightly fast; nothing counts its edges.
  initial quartz_clk = 1'b0;
  always #18 quartz_clk = ~quartz_clk;
  assign ext_field_det = field_req;
  initial rx_evt = '0;
  initial peer_type_a_seen = 1'b0;
  initial peer_fsig_seen = 1'b0;
  // Framing, the sync byte included, stays plain host data; only decoded commands arrive.
  task automatic send(input rft_pkg::rft_card_cmd_t c, input logic m);
    @(posedge clk_sys);
    rx_evt <= '{valid: 1'b1, cmd: c, uid_match: m};
    @(posedge clk_sys);
    rx_evt <= '0;
  endtask
  task automatic type_a;
    @(posedge clk_sys);
    peer_type_a_seen <= 1'b1;
    @(posedge clk_sys);
    peer_type_a_seen <= 1'b0;
  endtask
  task automatic fsig;
    @(posedge clk_sys);
    peer_fsig_seen <= 1'b1;
    @(posedge clk_sys);
    peer_fsig_seen <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/rft_field_tx_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module rft_field_tx_tb;
  localparam int IDT = 8;
  localparam logic [7:0] ST = rft_pkg::ADDR_FIELD_STATUS;
  localparam logic [7:0] CS = rft_pkg::ADDR_CARD_STATUS;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic tx_envelope = 1'b0;
  logic meas_valid = 1'b0;
  logic [6:0] meas_residual = 7'h32;
  logic field_req = 1'b0;
  logic quartz_clk, ext_field_det, peer_type_a_seen, peer_fsig_seen, tx_answer_valid;
  logic field_collision_error_irq, card_activated_irq;
  rft_pkg::rft_rx_evt_t rx_evt;
  rft_pkg::rft_drv_pins_t antenna_drive_a, antenna_drive_b;
  rft_pkg::rft_answer_t tx_answer_kind;
  logic [1:0] card_rate;
  logic [4:0] mod_depth_trim;
  logic [2:0] modes [6] = '{3'h2, 3'h1, 3'h0, 3'h6, 3'h5, 3'h7};
  logic [3:0] pins [3] = '{4'hA, 4'h5, 4'h0};
  int bad_count = 0;
  int checked = 0;
  always #2 clk_sys = ~clk_sys;
  rft_field_tx #(.IDT_CYCLES(IDT)) dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .quartz_clk, .ext_field_det, .tx_envelope, .meas_valid,
    .meas_residual, .rx_evt, .peer_type_a_seen, .peer_fsig_seen, .antenna_drive_a,
    .antenna_drive_b, .mod_depth_trim, .tx_answer_valid, .tx_answer_kind, .card_rate,
    .field_collision_error_irq, .card_activated_irq);
  rft_rf_peer peer (.clk_sys, .field_req, .quartz_clk, .ext_field_det, .rx_evt,
    .peer_type_a_seen, .peer_fsig_seen);
  // ----
  // Access and compare tasks
  // ----
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(n, reg_rdata, e);
  endtask
  task automatic meas(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      meas_valid <= 1'b1;
      @(posedge clk_sys);
      meas_valid <= 1'b0;
    end
  endtask
  task automatic card(input rft_pkg::rft_card_cmd_t c, input rft_pkg::rft_answer_t k);
    peer.send(c, 1'b1);
    #1 check("answer", {tx_answer_valid, tx_answer_kind}, {1'b1, k});
  endtask
  task automatic finish_test;
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rd(ST, 32'h0, "status_reset");
    rd(8'h3C, 32'h0, "unmapped");
    wr(rft_pkg::ADDR_COMMAND, 32'h1);
    rd(ST, 32'h2, "listening");
    repeat (IDT + 4) @(posedge clk_sys);
    rd(ST, 32'h1, "carrier_on");
    check("push_pull", antenna_drive_a.hs_on ^ antenna_drive_a.ls_on, 1);
    wr(rft_pkg::ADDR_CLK_CTRL, 32'h8);
    repeat (2) @(posedge clk_sys);
    #1 check("invert_a", antenna_drive_a.hs_on ^ antenna_drive_b.hs_on, 1);
    wr(rft_pkg::ADDR_CARD_CTRL, 32'h1);
    wr(rft_pkg::ADDR_CLK_CTRL, 32'hA0);
    repeat (2) @(posedge clk_sys);
    #1 check("invert_card", antenna_drive_a.hs_on ^ antenna_drive_b.hs_on, 1);
    @(posedge clk_sys);
    tx_envelope <= 1'b1;
    foreach (modes[i]) begin
      wr(rft_pkg::ADDR_CLK_CTRL, {29'h0, modes[i]});
      @(posedge clk_sys);
      #1;
      if (i < 3) check("mode", {antenna_drive_a, antenna_drive_b}, pins[i]);
      if (i == 3) check("hs_only", {antenna_drive_a.ls_on, antenna_drive_b.ls_on}, 0);
      if (i == 4) check("ls_only", {antenna_drive_a.hs_on, antenna_drive_b.hs_on}, 0);
      if (i == 5) check("mode_pp", ^antenna_drive_a && ^antenna_drive_b, 1);
    end
    @(posedge clk_sys);
    tx_envelope <= 1'b0;
    wr(rft_pkg::ADDR_TX_CTRL, 32'h1F);
    meas(3);
    rd(CS, 32'h30, "trim_up");
    check("trim_port", mod_depth_trim, 5'h03);
    wr(rft_pkg::ADDR_TX_CTRL, 32'h0);
    meas(5);
    rd(CS, 32'h0, "trim_floor");
    wr(rft_pkg::ADDR_COMMAND, 32'h2);
    rd(ST, 32'h0, "field_off");
    check("drv_off", {antenna_drive_a, antenna_drive_b}, 0);
    @(posedge clk_sys);
    field_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(rft_pkg::ADDR_COMMAND, 32'h1);
    repeat (IDT + 4) @(posedge clk_sys);
    rd(ST, 32'h1C, "collision");
    check("err_irq", field_collision_error_irq, 1);
    for (int r = 0; r < 4; r++) begin
      wr(rft_pkg::ADDR_CARD_CTRL, 32'h3 | (r << 2));
      #1 check("rate", card_rate, r[1:0]);
    end
    card(rft_pkg::CMD_WAKE, rft_pkg::ANS_ATQA);
    card(rft_pkg::CMD_ANTICOLL, rft_pkg::ANS_UID);
    card(rft_pkg::CMD_SELECT, rft_pkg::ANS_SAK);
    check("act_irq", card_activated_irq, 1);
    peer.send(rft_pkg::CMD_HALT, 1'b1);
    #1 check("halt_quiet", tx_answer_valid, 0);
    card(rft_pkg::CMD_WAKE, rft_pkg::ANS_ATQA);
    peer.type_a();
    rd(CS, 32'h0B, "card_status");
    peer.fsig();
    rd(CS, 32'h0D, "fsig_peer");
    wr(CS, 32'h1);
    #1 check("act_clear", card_activated_irq, 0);
    rd(ST, 32'h1C, "status_held");
    @(posedge clk_sys);
    field_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr(rft_pkg::ADDR_COMMAND, 32'h1);
    #1 check("err_clear", field_collision_error_irq, 0);
    finish_test();
  end
endmodule
`default_nettype wire
